// >>> verilog/mem_bus_pkg.sv
// Behaviour
// - read_not_write is high for a transfer that reads an external device and low for one that writes it.
// - read_output_strobe goes low only during a device read, the one window where the device drives the data bus.
// - The four low-active byte lane strobes act as data masks for SDRAM and as per-byte write enables for devices.
// - Strobe bit 0 covers data bits 7:0, bit 1 bits 15:8, bit 2 bits 23:16 and bit 3 bits 31:24.
// - Of the two low-active SDRAM chip selects only the one for the SDRAM being accessed goes low.
// - row_strobe is a low-active row address strobe used during SDRAM transfers.
// - column_strobe is a low-active column address strobe used during SDRAM transfers.
// - sdram_write_strobe goes low during SDRAM write and precharge commands and stays high otherwise.
// - sdram_clock_gate is high during active SDRAM clock cycles.
// - SDRAM read data is taken on the rising edge of read_capture_clock, a board-delayed system clock copy.
package mem_bus_pkg;

  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int NUM_CS  = 2;
  localparam int ROW_W   = 13;
  localparam int COL_W   = 9;
  localparam int ADDR_W  = ROW_W + COL_W;
  localparam int CNT_W   = 4;

  // Default cycle counts, each the number of clocks spent in that phase
  localparam int RCD_CYCLES = 2;
  localparam int CAS_CYCLES = 2;
  localparam int RP_CYCLES  = 2;
  localparam int DEV_CYCLES = 3;

  localparam logic [LANES-1:0]  STROBE_IDLE = 4'hF;
  localparam logic [NUM_CS-1:0] CS_IDLE     = 2'h3;
  localparam logic [NUM_CS-1:0] CS_ONE      = 2'h1;
  localparam logic              RWN_IDLE    = 1'h1;

  typedef struct packed {
    logic ras_b;
    logic cas_b;
    logic we_b;
  } sdram_cmd_t;

  localparam sdram_cmd_t CMD_NOP   = 3'h7;
  localparam sdram_cmd_t CMD_ACT   = 3'h3;
  localparam sdram_cmd_t CMD_READ  = 3'h5;
  localparam sdram_cmd_t CMD_WRITE = 3'h4;
  localparam sdram_cmd_t CMD_PRE   = 3'h2;

  typedef struct packed {
    logic              sdram;
    logic              cs_sel;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  byte_en;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACT  = 3'h1,
    ST_RCD  = 3'h2,
    ST_CMD  = 3'h3,
    ST_LAT  = 3'h4,
    ST_PRE  = 3'h5,
    ST_DEV  = 3'h6,
    ST_DONE = 3'h7
  } bus_state_t;

endpackage

// >>> verilog/mem_byte_lane.sv
`timescale 1ns/1ps
module mem_byte_lane #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // Lane control, already at next-cycle timing
  input  wire logic         enable_i,
  input  wire logic         strobe_on_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         capture_i,
  input  wire logic [W-1:0] bus_i,
  // Lane outputs
  output logic              strobe_b_o,
  output logic [W-1:0]      data_o,
  output logic [W-1:0]      rdata_o
);

  logic         strobe_b_next;
  logic [W-1:0] rdata_next;

  // One low-active strobe per lane, serving as mask or write enable
  assign strobe_b_next = !(strobe_on_i && enable_i);
  // Masked lanes read as zero so stale bytes never leak into a response
  assign rdata_next = capture_i ? (enable_i ? bus_i : '0) : rdata_o;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_b_o <= 1'h1;
      data_o     <= '0;
      rdata_o    <= '0;
    end else begin
      strobe_b_o <= strobe_b_next;
      data_o     <= wdata_i;
      rdata_o    <= rdata_next;
    end
  end

endmodule

// >>> verilog/mem_bus_ctrl.sv
`timescale 1ns/1ps
module mem_bus_ctrl #(
  parameter int RCD_CYCLES = mem_bus_pkg::RCD_CYCLES,
  parameter int CAS_CYCLES = mem_bus_pkg::CAS_CYCLES,
  parameter int RP_CYCLES  = mem_bus_pkg::RP_CYCLES,
  parameter int DEV_CYCLES = mem_bus_pkg::DEV_CYCLES
) (
  // Clock and reset
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_b_i,
  // Request side
  input  wire logic                               req_valid_i,
  input  wire mem_bus_pkg::mem_req_t              req_i,
  output logic                                    req_ready_o,
  output logic                                    rsp_valid_o,
  output logic [mem_bus_pkg::DATA_W-1:0]          rsp_rdata_o,
  // Bus control pins
  output logic                                    read_not_write_o,
  output logic                                    read_output_strobe_b_o,
  output logic                                    device_select_b_o,
  output logic [mem_bus_pkg::LANES-1:0]           byte_lane_write_strobes_b_o,
  output logic [mem_bus_pkg::ADDR_W-1:0]          mem_addr_o,
  // SDRAM pins
  output logic [mem_bus_pkg::NUM_CS-1:0]          sdram_chip_selects_b_o,
  output logic                                    row_strobe_b_o,
  output logic                                    column_strobe_b_o,
  output logic                                    sdram_write_strobe_b_o,
  output logic                                    sdram_clock_gate_o,
  input  wire logic                               read_capture_clock_i,
  // Data bus, split into in, out and enable
  input  wire logic [mem_bus_pkg::DATA_W-1:0]     memory_data_bus_i,
  output logic [mem_bus_pkg::DATA_W-1:0]          memory_data_bus_o,
  output logic                                    memory_data_bus_oe_o
);

  localparam int CW = mem_bus_pkg::CNT_W;
  localparam logic [CW-1:0] RCD_LOAD = CW'(RCD_CYCLES - 1);
  localparam logic [CW-1:0] CAS_LOAD = CW'(CAS_CYCLES - 1);
  localparam logic [CW-1:0] RP_LOAD  = CW'(RP_CYCLES - 1);
  localparam logic [CW-1:0] DEV_LOAD = CW'(DEV_CYCLES - 1);

  mem_bus_pkg::bus_state_t state_reg;
  mem_bus_pkg::bus_state_t state_next;
  mem_bus_pkg::mem_req_t   req_reg;
  mem_bus_pkg::mem_req_t   req_next;
  mem_bus_pkg::sdram_cmd_t cmd_next;
  logic [CW-1:0]           cnt_reg;
  logic [CW-1:0]           cnt_next;
  logic                    cap_prev_reg;

  logic                               accept_w;
  logic                               cnt_zero_w;
  logic [CW-1:0]                      cnt_dec_w;
  logic                               cap_rise_w;
  logic                               capture_w;
  logic                               sd_active_next;
  logic                               strobe_on_next;
  logic                               drive_next;
  logic [mem_bus_pkg::NUM_CS-1:0]     cs_b_next;
  logic                               rwn_next;
  logic                               oe_b_next;
  logic                               dev_sel_b_next;
  logic [mem_bus_pkg::ADDR_W-1:0]     addr_next;
  logic                               ready_next;
  logic                               rsp_valid_next;

  assign accept_w   = req_valid_i && req_ready_o;
  assign cnt_zero_w = (cnt_reg == '0);
  assign cnt_dec_w  = cnt_reg - CW'(1);
  assign req_next   = accept_w ? req_i : req_reg;

  // The capture clock is a board-delayed copy of the bus clock, so its rising
  // edge is seen here as a low-to-high step between two samples
  assign cap_rise_w = read_capture_clock_i && !cap_prev_reg;
  assign capture_w  = (state_reg == mem_bus_pkg::ST_LAT && cnt_zero_w && cap_rise_w) ||
                      (state_reg == mem_bus_pkg::ST_DEV && cnt_zero_w && !req_reg.write);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      mem_bus_pkg::ST_IDLE: begin
        if (accept_w) begin
          state_next = req_i.sdram ? mem_bus_pkg::ST_ACT : mem_bus_pkg::ST_DEV;
          cnt_next   = DEV_LOAD;
        end
      end
      mem_bus_pkg::ST_ACT: begin
        state_next = mem_bus_pkg::ST_RCD;
        cnt_next   = RCD_LOAD;
      end
      mem_bus_pkg::ST_RCD: begin
        if (cnt_zero_w) begin
          state_next = mem_bus_pkg::ST_CMD;
        end else begin
          cnt_next = cnt_dec_w;
        end
      end
      mem_bus_pkg::ST_CMD: begin
        state_next = req_reg.write ? mem_bus_pkg::ST_PRE : mem_bus_pkg::ST_LAT;
        cnt_next   = CAS_LOAD;
      end
      mem_bus_pkg::ST_LAT: begin
        // Waits on the capture clock after the latency has run out
        if (!cnt_zero_w) begin
          cnt_next = cnt_dec_w;
        end else if (cap_rise_w) begin
          state_next = mem_bus_pkg::ST_PRE;
        end
      end
      mem_bus_pkg::ST_PRE: begin
        state_next = mem_bus_pkg::ST_DONE;
        cnt_next   = RP_LOAD;
      end
      mem_bus_pkg::ST_DEV: begin
        if (cnt_zero_w) begin
          state_next = mem_bus_pkg::ST_DONE;
          cnt_next   = RP_LOAD;
        end else begin
          cnt_next = cnt_dec_w;
        end
      end
      mem_bus_pkg::ST_DONE: begin
        if (cnt_zero_w) begin
          state_next = mem_bus_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_dec_w;
        end
      end
      default: begin
        state_next = mem_bus_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin values are decoded from the next state so every pin is a flop
  assign sd_active_next = (state_next == mem_bus_pkg::ST_ACT) ||
                          (state_next == mem_bus_pkg::ST_RCD) ||
                          (state_next == mem_bus_pkg::ST_CMD) ||
                          (state_next == mem_bus_pkg::ST_LAT) ||
                          (state_next == mem_bus_pkg::ST_PRE);

  assign cmd_next = (state_next == mem_bus_pkg::ST_ACT) ? mem_bus_pkg::CMD_ACT :
                    (state_next == mem_bus_pkg::ST_PRE) ? mem_bus_pkg::CMD_PRE :
                    (state_next != mem_bus_pkg::ST_CMD) ? mem_bus_pkg::CMD_NOP :
                    req_next.write ? mem_bus_pkg::CMD_WRITE :
                    mem_bus_pkg::CMD_READ;

  // Select stays low through the NOP waits so only one SDRAM sees the access
  assign cs_b_next = sd_active_next ? ~(mem_bus_pkg::CS_ONE << req_next.cs_sel) :
                     mem_bus_pkg::CS_IDLE;

  assign rwn_next = (state_next == mem_bus_pkg::ST_IDLE) ? mem_bus_pkg::RWN_IDLE :
                    !req_next.write;

  assign oe_b_next = !(state_next == mem_bus_pkg::ST_DEV && !req_next.write);

  assign dev_sel_b_next = (state_next != mem_bus_pkg::ST_DEV);

  // SDRAM masks cover the command and the read latency; device reads use no strobes
  assign strobe_on_next = (state_next == mem_bus_pkg::ST_CMD) ||
                          (state_next == mem_bus_pkg::ST_LAT) ||
                          (state_next == mem_bus_pkg::ST_DEV && req_next.write);

  assign drive_next = req_next.write && ((state_next == mem_bus_pkg::ST_CMD) ||
                                         (state_next == mem_bus_pkg::ST_DEV));

  assign addr_next = (state_next == mem_bus_pkg::ST_ACT) ?
                       mem_bus_pkg::ADDR_W'(req_next.addr[mem_bus_pkg::ADDR_W-1:mem_bus_pkg::COL_W]) :
                     (state_next == mem_bus_pkg::ST_CMD) ?
                       mem_bus_pkg::ADDR_W'(req_next.addr[mem_bus_pkg::COL_W-1:0]) :
                     req_next.addr;

  assign ready_next     = (state_next == mem_bus_pkg::ST_IDLE);
  assign rsp_valid_next = (state_next == mem_bus_pkg::ST_DONE) &&
                          (state_reg != mem_bus_pkg::ST_DONE);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= mem_bus_pkg::ST_IDLE;
      cnt_reg      <= '0;
      req_reg      <= '0;
      cap_prev_reg <= 1'h0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      req_reg      <= req_next;
      cap_prev_reg <= read_capture_clock_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_strobe_b_o         <= mem_bus_pkg::CMD_NOP.ras_b;
      column_strobe_b_o      <= mem_bus_pkg::CMD_NOP.cas_b;
      sdram_write_strobe_b_o <= mem_bus_pkg::CMD_NOP.we_b;
      sdram_chip_selects_b_o <= mem_bus_pkg::CS_IDLE;
      sdram_clock_gate_o     <= 1'h0;
      read_not_write_o       <= mem_bus_pkg::RWN_IDLE;
      read_output_strobe_b_o <= 1'h1;
      device_select_b_o      <= 1'h1;
      memory_data_bus_oe_o   <= 1'h0;
      mem_addr_o             <= '0;
      req_ready_o            <= 1'h0;
      rsp_valid_o            <= 1'h0;
    end else begin
      row_strobe_b_o         <= cmd_next.ras_b;
      column_strobe_b_o      <= cmd_next.cas_b;
      sdram_write_strobe_b_o <= cmd_next.we_b;
      sdram_chip_selects_b_o <= cs_b_next;
      sdram_clock_gate_o     <= sd_active_next;
      read_not_write_o       <= rwn_next;
      read_output_strobe_b_o <= oe_b_next;
      device_select_b_o      <= dev_sel_b_next;
      memory_data_bus_oe_o   <= drive_next;
      mem_addr_o             <= addr_next;
      req_ready_o            <= ready_next;
      rsp_valid_o            <= rsp_valid_next;
    end
  end

  // Lane i owns strobe bit i and data bits 8i+7 down to 8i
  genvar gi;
  generate
    for (gi = 0; gi < mem_bus_pkg::LANES; gi++) begin : g_lane
      mem_byte_lane #(
        .W (mem_bus_pkg::LANE_W)
      ) u_lane (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .enable_i    (req_next.byte_en[gi]),
        .strobe_on_i (strobe_on_next),
        .wdata_i     (req_next.wdata[gi*mem_bus_pkg::LANE_W +: mem_bus_pkg::LANE_W]),
        .capture_i   (capture_w),
        .bus_i       (memory_data_bus_i[gi*mem_bus_pkg::LANE_W +: mem_bus_pkg::LANE_W]),
        .strobe_b_o  (byte_lane_write_strobes_b_o[gi]),
        .data_o      (memory_data_bus_o[gi*mem_bus_pkg::LANE_W +: mem_bus_pkg::LANE_W]),
        .rdata_o     (rsp_rdata_o[gi*mem_bus_pkg::LANE_W +: mem_bus_pkg::LANE_W])
      );
    end
  endgenerate

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_act;
    !row_strobe_b_o && column_strobe_b_o && sdram_write_strobe_b_o;
  endsequence

  sequence s_col;
    row_strobe_b_o && !column_strobe_b_o;
  endsequence

  sequence s_pre;
    !row_strobe_b_o && column_strobe_b_o && !sdram_write_strobe_b_o;
  endsequence

  chk_rwn_direction: assert property (
    (state_reg == mem_bus_pkg::ST_DEV) |-> (read_not_write_o == !req_reg.write))
    else $error("read_not_write does not match the transfer direction");

  chk_oe_window: assert property (
    !read_output_strobe_b_o |-> read_not_write_o && !memory_data_bus_oe_o && !device_select_b_o)
    else $error("read output strobe low outside a device read");

  chk_strobe_mask: assert property (
    (state_reg == mem_bus_pkg::ST_CMD) |-> (byte_lane_write_strobes_b_o == ~req_reg.byte_en))
    else $error("byte lane strobes do not follow the byte enables");

  chk_lane_top_byte: assert property (
    memory_data_bus_oe_o |-> (memory_data_bus_o[31:24] == req_reg.wdata[31:24]) &&
                             (byte_lane_write_strobes_b_o[3] == !req_reg.byte_en[3]))
    else $error("top byte lane not tied to strobe bit 3");

  chk_cs_select: assert property (
    (sdram_chip_selects_b_o != mem_bus_pkg::CS_IDLE) |->
      (sdram_chip_selects_b_o == ~(mem_bus_pkg::CS_ONE << req_reg.cs_sel)))
    else $error("wrong or extra SDRAM chip select low");

  chk_act_pulse: assert property (
    s_act |-> (sdram_chip_selects_b_o != mem_bus_pkg::CS_IDLE) ##1 row_strobe_b_o)
    else $error("activate not a single selected cycle");

  chk_col_pulse: assert property (
    s_col |-> (sdram_chip_selects_b_o != mem_bus_pkg::CS_IDLE) ##1 column_strobe_b_o)
    else $error("column command not a single selected cycle");

  chk_we_write: assert property (
    (s_col and !sdram_write_strobe_b_o) |-> !read_not_write_o && memory_data_bus_oe_o)
    else $error("SDRAM write strobe without a write");

  chk_gate_active: assert property (
    (sdram_chip_selects_b_o != mem_bus_pkg::CS_IDLE) |-> sdram_clock_gate_o)
    else $error("SDRAM selected with its clock gated off");

  chk_capture_edge: assert property (
    (state_reg == mem_bus_pkg::ST_LAT && cnt_zero_w && cap_rise_w && req_reg.byte_en[0]) |=>
      (rsp_rdata_o[7:0] == $past(memory_data_bus_i[7:0])))
    else $error("read data not taken on the capture clock edge");

  chk_cmd_order: assert property (
    s_act |-> ##[2:16] s_col ##[1:300] s_pre)
    else $error("SDRAM command order broken");

endmodule

// >>> verification/mem_bus_partner.sv
`timescale 1ns/1ps
module mem_bus_partner (
  // Clock, reset and pace
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    slow_i,
  // Pins from the controller
  input  wire logic                    read_not_write_i,
  input  wire logic                    rd_strobe_b_i,
  input  wire logic                    dev_sel_b_i,
  input  wire logic [3:0]              strobes_b_i,
  input  wire logic [21:0]             addr_i,
  input  wire logic [1:0]              cs_b_i,
  input  wire mem_bus_pkg::sdram_cmd_t cmd_i,
  input  wire logic [31:0]             data_i,
  input  wire logic                    data_oe_i,
  // Pins back to the controller
  output logic                         cap_clk_o,
  output logic [31:0]                  bus_o
);
  logic [31:0] mem [0:31];
  logic [31:0] last_q;
  logic [4:0]  key_q;
  logic [3:0]  mask_q;
  logic        rd_q;
  int          wait_q;
  logic        drv;
  logic        sd_sel;
  logic [31:0] word;

  assign sd_sel = (cs_b_i != 2'h3);
  // Read data is valid only around the capture edge, so early or late sampling sees junk
  assign drv  = (!rd_strobe_b_i && !dev_sel_b_i) || (rd_q && cap_clk_o);
  assign word = mem[rd_q ? key_q : {1'b0, addr_i[3:0]}];

  always_comb begin
    bus_o = ~last_q;
    if (drv) begin
      bus_o = word;
      for (int i = 0; i < 4; i++) begin
        if (rd_q && mask_q[i]) begin
          bus_o[8*i +: 8] = ~word[8*i +: 8];
        end
      end
    end
    if (data_oe_i) begin
      bus_o = data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q   <= 1'b0;
      key_q  <= 5'h00;
      mask_q <= 4'hF;
      last_q <= 32'h0000_0000;
    end else begin
      last_q <= bus_o;
      if (sd_sel && cmd_i == mem_bus_pkg::CMD_READ) begin
        rd_q   <= 1'b1;
        key_q  <= {1'b1, addr_i[3:0]};
        mask_q <= strobes_b_i;
      end
      if (sd_sel && cmd_i == mem_bus_pkg::CMD_PRE) begin
        rd_q <= 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
        if (sd_sel && cmd_i == mem_bus_pkg::CMD_WRITE && !strobes_b_i[i] && data_oe_i) begin
          mem[{1'b1, addr_i[3:0]}][8*i +: 8] <= data_i[8*i +: 8];
        end
        if (!dev_sel_b_i && !read_not_write_i && !strobes_b_i[i] && data_oe_i) begin
          mem[{1'b0, addr_i[3:0]}][8*i +: 8] <= data_i[8*i +: 8];
        end
      end
    end
  end

  // Capture clock stands still outside SDRAM reads
  always_ff @(negedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_clk_o <= 1'b0;
      wait_q    <= 0;
    end else if (!rd_q) begin
      cap_clk_o <= 1'b0;
      wait_q    <= 0;
    end else if (wait_q < (slow_i ? 6 : 1)) begin
      wait_q <= wait_q + 1;
    end else begin
      cap_clk_o <= ~cap_clk_o;
    end
  end
endmodule

// >>> verification/tb_memory_bus_pin_signalling.sv
`timescale 1ns/1ps
module tb_memory_bus_pin_signalling;
  localparam int RCD = 3;
  localparam int CAS = 2;
  localparam int RP  = 3;
  localparam int DEV = 4;

  logic                    clk_sys_i;
  logic                    rst_b_i;
  logic                    req_valid;
  logic                    slow;
  mem_bus_pkg::mem_req_t   req;
  mem_bus_pkg::sdram_cmd_t cmd;
  logic                    req_ready, rsp_valid, read_not_write, rd_strobe_b, dev_sel_b;
  logic                    cap_clk, gate, bus_oe;
  logic [3:0]              strobes_b;
  logic [21:0]             addr;
  logic [1:0]              cs_b;
  logic [31:0]             rdata, bus_in, bus_out;
  logic [31:0]             shadow [0:31];
  int                      n_fail;
  int                      num_checks;

  mem_bus_ctrl #(.RCD_CYCLES(RCD), .CAS_CYCLES(CAS), .RP_CYCLES(RP), .DEV_CYCLES(DEV)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata),
    .read_not_write_o(read_not_write), .read_output_strobe_b_o(rd_strobe_b), .device_select_b_o(dev_sel_b),
    .byte_lane_write_strobes_b_o(strobes_b), .mem_addr_o(addr), .sdram_chip_selects_b_o(cs_b),
    .row_strobe_b_o(cmd.ras_b), .column_strobe_b_o(cmd.cas_b), .sdram_write_strobe_b_o(cmd.we_b),
    .sdram_clock_gate_o(gate), .read_capture_clock_i(cap_clk), .memory_data_bus_i(bus_in),
    .memory_data_bus_o(bus_out), .memory_data_bus_oe_o(bus_oe));

  mem_bus_partner u_partner (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .slow_i(slow), .read_not_write_i(read_not_write),
    .rd_strobe_b_i(rd_strobe_b), .dev_sel_b_i(dev_sel_b), .strobes_b_i(strobes_b),
    .addr_i(addr), .cs_b_i(cs_b), .cmd_i(cmd), .data_i(bus_out), .data_oe_i(bus_oe),
    .cap_clk_o(cap_clk), .bus_o(bus_in));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("unexpected %s: expected completion, seen hang", what);
    wrap_up();
  endtask

  task automatic t_reset();
    rst_b_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk("idle pins", {read_not_write, rd_strobe_b, dev_sel_b, strobes_b, cs_b, cmd, gate, bus_oe, req_ready},
        {1'b1, 1'b1, 1'b1, 4'hF, 2'h3, 3'h7, 1'b0, 1'b0, 1'b0});
    rst_b_i = 1'b1;
    @(negedge clk_sys_i);
    chk("ready after reset", req_ready, 1'b1);
  endtask

  // One whole transfer, checking the pins of every selected cycle until the response
  task automatic xfer(input logic sd, input logic cs, input logic wr, input logic [3:0] idx,
                      input logic [3:0] be, input logic [31:0] wd, input logic sl);
    logic [31:0] m;
    logic [1:0]  cs_on;
    int          n;
    int          acts;
    int          cmds;
    int          pres;
    m     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    cs_on = cs ? 2'h1 : 2'h2;
    slow  = sl;
    req   = '0;
    req.sdram   = sd;
    req.cs_sel  = cs;
    req.write   = wr;
    req.addr    = {13'h0005, 5'h00, idx};
    req.byte_en = be;
    req.wdata   = wd;
    @(negedge clk_sys_i);
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 50) give_up("ready");
    @(negedge clk_sys_i);
    req_valid = 1'b0;
    n = 0;
    acts = 0;
    cmds = 0;
    pres = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      if (cs_b !== 2'h3) begin
        chk("chip select", cs_b, sd ? cs_on : 2'h3);
        chk("clock gate", gate, 1'b1);
        if (cmd === mem_bus_pkg::CMD_ACT) begin
          acts++;
          chk("row address", addr, 22'h5);
        end
        if (cmd === mem_bus_pkg::CMD_READ || cmd === mem_bus_pkg::CMD_WRITE) begin
          cmds++;
          chk("column command", cmd, wr ? mem_bus_pkg::CMD_WRITE : mem_bus_pkg::CMD_READ);
          chk("column address", addr[8:0], {5'h0, idx});
          chk("lane mask", {read_not_write, strobes_b}, {!wr, ~be});
          if (wr) chk("write data", {bus_oe, bus_out & m}, {1'b1, wd & m});
        end
        if (cmd === mem_bus_pkg::CMD_PRE) pres++;
      end
      chk("output strobe", rd_strobe_b, sd | wr | dev_sel_b);
      if (dev_sel_b === 1'b0) begin
        chk("device pins", {sd, read_not_write, strobes_b, bus_oe, addr, wr ? bus_out & m : 32'h0},
            {1'b0, !wr, wr ? ~be : 4'hF, wr, req.addr, wr ? wd & m : 32'h0});
      end
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 100) give_up("response");
    // Pins change on the accept edge itself; counted from the request cycle the pulse sits at n + 1
    if (!(sd && !wr)) chk("response cycle", n + 1, sd ? 4 + RCD : 1 + DEV);
    if (sd) chk("command count", {acts[3:0], cmds[3:0], pres[3:0]}, 12'h111);
    if (!wr) begin
      chk("read data", rdata, shadow[{sd, idx}] & m);
    end else begin
      shadow[{sd, idx}] = (shadow[{sd, idx}] & ~m) | (wd & m);
    end
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 50) give_up("recovery");
    chk("recovery", n, RP);
  endtask

  task automatic t_device();
    xfer(1'b0, 1'b0, 1'b1, 4'h3, 4'hF, 32'hA5C3_0F96, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 4'h3, 4'h5, 32'h1234_5678, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 4'h3, 4'hF, 32'h0, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 4'h3, 4'h6, 32'h0, 1'b0);
  endtask

  // Both chip selects, partial masks, prompt and late capture clock
  task automatic t_sdram();
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, c[0], 1'b1, 4'h9, 4'hF, 32'h0BAD_F00D ^ c, 1'b0);
      xfer(1'b1, c[0], 1'b1, 4'h9, 4'hA, 32'h7E57_C0DE, 1'b0);
      xfer(1'b1, c[0], 1'b0, 4'h9, 4'hF, 32'h0, 1'b0);
      xfer(1'b1, c[0], 1'b0, 4'h9, 4'h3, 32'h0, 1'b1);
    end
  endtask

  // Reset lands before the write command, so memory must stay untouched
  task automatic t_midreset();
    req = '0;
    req.sdram = 1'b1;
    req.write = 1'b1;
    req.addr  = 22'h9;
    @(negedge clk_sys_i);
    req_valid = 1'b1;
    @(negedge clk_sys_i);
    req_valid = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    t_reset();
    xfer(1'b1, 1'b1, 1'b0, 4'h9, 4'hF, 32'h0, 1'b0);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    n_fail     = 0;
    num_checks = 0;
    rst_b_i    = 1'b0;
    req_valid  = 1'b0;
    req        = '0;
    slow       = 1'b0;
    t_reset();
    t_device();
    t_sdram();
    t_midreset();
    wrap_up();
  end
endmodule
